// ===== hw/spm_phy_ctrl.sv
`timescale 1ns/1ps
//Contract
//- symbol period 50/25/40/16 us per mode
//- high rate keeps its base mode's period
//- spreading shortened two- or four-fold
//- header at base rate, psdu at high
//- reduced ack: two or three symbols
//- normal ack time twelve symbols
//- ignore frames below programmed detector level
//- scrambler on at 4-fold unless disabled
//- auto energy detect eight, high-rate two symbols
//- manual energy detect always eight symbols
//- high rate: energy threshold cca only
//- listen, sync plus delimiter enters busy
//- frame complete returns busy to listen
//- append quality, energy, status after frame
//- energy level and fcs flag readable
//- mode decoded from control bits, bit5 scrambler
module spm_phy_ctrl import spm_pkg::*; #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic CLK_EN_I,
   input wire logic MODE_WR_I,
   input wire logic [5:0] MODE_DATA_I,
   input wire logic REDUCED_ACK_TIME_I,
   input wire logic [3:0] DETECTOR_LEVEL_I,
   input wire logic RX_ON_CMD_I,
   input wire logic OFF_CMD_I,
   input wire logic [4:0] RSSI_I,
   input wire logic SYNC_FOUND_I,
   input wire logic SFD_FOUND_I,
   input wire logic PSDU_START_I,
   input wire logic FRAME_DONE_I,
   input wire logic FCS_OK_I,
   input wire logic [7:0] LQI_I,
   input wire logic RX_DATA_VALID_I,
   input wire logic [7:0] RX_DATA_I,
   output logic RX_DATA_READY_O,
   input wire logic ED_AUTO_START_I,
   input wire logic ED_MANUAL_START_I,
   output logic ED_BUSY_O,
   output logic ED_DONE_O,
   output logic [7:0] ENERGY_LEVEL_O,
   input wire logic ACK_START_I,
   output logic ACK_DUE_O,
   output logic [3:0] ACK_SYMBOLS_O,
   input wire logic [1:0] CCA_MODE_I,
   output logic [1:0] CCA_MODE_O,
   output logic SYMBOL_TICK_O,
   output logic [5:0] SYMBOL_PERIOD_US_O,
   output logic [2:0] SPREAD_FACTOR_O,
   output logic HIGH_RATE_MODE_O,
   output logic HIGH_RATE_ACTIVE_O,
   output logic [10:0] DATA_RATE_KBPS_O,
   output logic SCRAMBLE_EN_O,
   output logic LQI_USEFUL_O,
   output logic [5:0] MODE_O,
   output logic [4:0] STATE_O,
   output logic FCS_VALID_O,
   output logic BUF_VALID_O,
   output logic [7:0] BUF_DATA_O,
   input wire logic BUF_READY_I
);
   spm_state_e state_ff; // receive flow state
   spm_state_e nxt_state; // next receive flow state
   logic [5:0] mode_ff; // held phy mode control word
   spm_mode_s nxt_dec; // decoded mode, combinational
   spm_mode_s dec_ff; // decoded mode, registered
   logic [9:0] sym_cnt_ff; // symbol timebase counter
   logic sym_tick_ff; // one-cycle pulse after each full symbol count
   logic sync_seen_ff; // sync seen, awaiting delimiter
   logic rssi_ok; // signal above detector level
   logic psdu_ff; // payload part of the frame in progress
   logic [1:0] app_idx_ff; // index of appended byte
   logic [4:0] frame_rssi_ff; // frame peak strength
   spm_frame_stat_s stat_ff; // captured per-frame status
   logic fcs_valid_ff; // last frame checksum result
   logic [13:0] ack_cnt_ff; // ack countdown in cycles
   logic ack_run_ff; // ack countdown running
   logic ack_due_ff; // ack time reached pulse
   logic [3:0] ack_syms; // ack length in symbols
   logic [13:0] ed_cnt_ff; // energy detect countdown
   logic ed_run_ff; // energy detect running
   logic ed_done_ff; // energy detect finished pulse
   logic [4:0] ed_peak_ff; // measurement peak strength
   logic [7:0] energy_level_ff; // last energy detect result
   logic [3:0] ed_syms; // energy detect length in symbols
   logic [10:0] rate_ff; // currently applied data rate
   logic fifo_in_valid; // write into frame buffer queue
   logic fifo_in_ready; // queue can take a byte
   logic [7:0] fifo_in_data; // byte to queue
   logic frame_end; // frame completed while busy

   // mode word is taken only in the off state
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         mode_ff <= MODE_RESET;
      end
      else if (CLK_EN_I && MODE_WR_I && state_ff == ST_OFF)
      begin
         mode_ff <= MODE_DATA_I;
      end
   end

   // decode the mode word into timing and rate settings
   always_comb
   begin
      nxt_dec = '0;
      nxt_dec.oqpsk = mode_ff[MOD_BIT];
      nxt_dec.chip1000 = mode_ff[RATE_BIT];
      nxt_dec.high_rate = mode_ff[MOD_BIT] && (mode_ff[HRS_LSB+:2] != HRS_BASE);
      // shortened spreading codes
      unique case (mode_ff[HRS_LSB+:2])
         HRS_X2, HRS_X2_ALT: nxt_dec.spread = mode_ff[MOD_BIT] ? 3'h2 : 3'h1;
         HRS_X4: nxt_dec.spread = mode_ff[MOD_BIT] ? 3'h4 : 3'h1;
         HRS_BASE: nxt_dec.spread = 3'h1;
      endcase
      // scrambling only four-fold, enabled by bit5
      nxt_dec.scramble = mode_ff[MOD_BIT] && (mode_ff[HRS_LSB+:2] == HRS_X4) && mode_ff[SCR_BIT];
      // period follows chip rate, so high rate keeps base period
      if (!mode_ff[MOD_BIT])
      begin
         nxt_dec.sym_cyc = mode_ff[RATE_BIT] ? SYM_CYC_BPSK40 : SYM_CYC_BPSK20;
         nxt_dec.sym_us = mode_ff[RATE_BIT] ? 6'(SYM_US_BPSK40) : 6'(SYM_US_BPSK20);
         nxt_dec.base_kbps = mode_ff[RATE_BIT] ? KBPS_40 : KBPS_20;
      end
      else
      begin
         nxt_dec.sym_cyc = mode_ff[RATE_BIT] ? SYM_CYC_OQPSK1000K : SYM_CYC_OQPSK400K;
         nxt_dec.sym_us = mode_ff[RATE_BIT] ? 6'(SYM_US_OQPSK1000K) : 6'(SYM_US_OQPSK400K);
         nxt_dec.base_kbps = mode_ff[RATE_BIT] ? KBPS_250 : KBPS_100;
      end
      // payload rate is the base rate times the shortening factor
      nxt_dec.psdu_kbps = 11'(nxt_dec.base_kbps * nxt_dec.spread);
   end

   // registered copy of the decoded mode
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         dec_ff <= '0;
      end
      else if (CLK_EN_I)
      begin
         dec_ff <= nxt_dec;
      end
   end

   // symbol timebase, runs while receiver on
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         sym_cnt_ff <= '0;
         sym_tick_ff <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         if (state_ff == ST_OFF)
         begin
            sym_cnt_ff <= '0;
            sym_tick_ff <= 1'b0;
         end
         else if (sym_cnt_ff >= dec_ff.sym_cyc - 10'h001)
         begin
            sym_cnt_ff <= '0;
            sym_tick_ff <= 1'b1;
         end
         else
         begin
            sym_cnt_ff <= sym_cnt_ff + 10'h001;
            sym_tick_ff <= 1'b0;
         end
      end
   end

   // detector gate: zero passes every frame
   assign rssi_ok = (DETECTOR_LEVEL_I == 4'h0) || (RSSI_I >= {1'b0, DETECTOR_LEVEL_I});
   assign frame_end = (state_ff == ST_BUSY) && FRAME_DONE_I;

   // receive flow
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_OFF:
         begin
            if (RX_ON_CMD_I)
            begin
               nxt_state = ST_LISTEN;
            end
         end
         ST_LISTEN:
         begin
            // sync then delimiter, both above the detector level
            if (OFF_CMD_I)
            begin
               nxt_state = ST_OFF;
            end
            else if (sync_seen_ff && SFD_FOUND_I && rssi_ok)
            begin
               nxt_state = ST_BUSY;
            end
         end
         ST_BUSY:
         begin
            if (FRAME_DONE_I)
            begin
               nxt_state = ST_APPEND;
            end
         end
         ST_APPEND:
         begin
            // back to listen once the trailing bytes are queued
            if (fifo_in_ready && app_idx_ff == APPEND_LAST)
            begin
               nxt_state = ST_LISTEN;
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         state_ff <= ST_OFF;
      end
      else if (CLK_EN_I)
      begin
         state_ff <= nxt_state;
      end
   end

   // sync latch, cleared when listening stops
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         sync_seen_ff <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         if (state_ff != ST_LISTEN || nxt_state != ST_LISTEN)
         begin
            sync_seen_ff <= 1'b0;
         end
         else if (SYNC_FOUND_I && rssi_ok)
         begin
            sync_seen_ff <= 1'b1;
         end
      end
   end

   // payload phase and applied data rate
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         psdu_ff <= 1'b0;
         rate_ff <= KBPS_20;
      end
      else if (CLK_EN_I)
      begin
         if (state_ff != ST_BUSY || FRAME_DONE_I)
         begin
            psdu_ff <= 1'b0;
         end
         else if (PSDU_START_I)
         begin
            psdu_ff <= 1'b1;
         end
         // header always at base rate, payload at the selected rate
         rate_ff <= psdu_ff ? dec_ff.psdu_kbps : dec_ff.base_kbps;
      end
   end

   // per-frame status capture
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         frame_rssi_ff <= '0;
         stat_ff <= '0;
         fcs_valid_ff <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         if (state_ff == ST_LISTEN)
         begin
            frame_rssi_ff <= RSSI_I;
         end
         else if (state_ff == ST_BUSY && RSSI_I > frame_rssi_ff)
         begin
            frame_rssi_ff <= RSSI_I;
         end
         if (frame_end)
         begin
            stat_ff.lqi <= LQI_I;
            stat_ff.ed <= {3'h0, frame_rssi_ff};
            stat_ff.rx_status <= 8'(FCS_OK_I) << RXS_FCS_BIT;
            fcs_valid_ff <= FCS_OK_I;
         end
      end
   end

   // index of the byte being appended
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         app_idx_ff <= '0;
      end
      else if (CLK_EN_I)
      begin
         if (state_ff != ST_APPEND)
         begin
            app_idx_ff <= '0;
         end
         else if (fifo_in_ready)
         begin
            app_idx_ff <= app_idx_ff + 2'h1;
         end
      end
   end

   // queue input: frame bytes, then three status bytes
   always_comb
   begin
      fifo_in_valid = 1'b0;
      fifo_in_data = RX_DATA_I;
      if (state_ff == ST_BUSY)
      begin
         fifo_in_valid = RX_DATA_VALID_I;
      end
      else if (state_ff == ST_APPEND)
      begin
         fifo_in_valid = 1'b1;
         unique case (app_idx_ff)
            2'h0: fifo_in_data = stat_ff.lqi;
            2'h1: fifo_in_data = stat_ff.ed;
            default: fifo_in_data = stat_ff.rx_status;
         endcase
      end
   end

   assign RX_DATA_READY_O = (state_ff == ST_BUSY) && fifo_in_ready;

   // frame buffer queue toward the host
   spm_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk_i(CLK_I),
      .reset_n_i(RESET_N_I),
      .clk_en_i(CLK_EN_I),
      .in_valid_i(fifo_in_valid),
      .in_ready_o(fifo_in_ready),
      .in_data_i(fifo_in_data),
      .out_valid_o(BUF_VALID_O),
      .out_ready_i(BUF_READY_I),
      .out_data_o(BUF_DATA_O)
   );

   // acknowledgment length in symbols
   always_comb
   begin
      if (REDUCED_ACK_TIME_I && dec_ff.high_rate)
      begin
         ack_syms = dec_ff.chip1000 ? ACK_SYM_HR1000K : ACK_SYM_HR400K;
      end
      else
      begin
         ack_syms = ACK_SYM_STD;
      end
   end

   // ack timer, pulse after ack time
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ack_cnt_ff <= '0;
         ack_run_ff <= 1'b0;
         ack_due_ff <= 1'b0;
      end
      else if (CLK_EN_I)
      begin
         ack_due_ff <= 1'b0;
         if (ACK_START_I)
         begin
            ack_cnt_ff <= 14'(ack_syms * dec_ff.sym_cyc) - 14'h0001;
            ack_run_ff <= 1'b1;
         end
         else if (ack_run_ff && ack_cnt_ff == '0)
         begin
            ack_run_ff <= 1'b0;
            ack_due_ff <= 1'b1;
         end
         else if (ack_run_ff)
         begin
            ack_cnt_ff <= ack_cnt_ff - 14'h0001;
         end
      end
   end

   // ed length: short only for auto high rate
   assign ed_syms = (ED_AUTO_START_I && !ED_MANUAL_START_I && dec_ff.high_rate) ? ED_SYM_HR : ED_SYM_STD;

   // energy detect, peak strength over window
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ed_cnt_ff <= '0;
         ed_run_ff <= 1'b0;
         ed_done_ff <= 1'b0;
         ed_peak_ff <= '0;
         energy_level_ff <= '0;
      end
      else if (CLK_EN_I)
      begin
         ed_done_ff <= 1'b0;
         if (!ed_run_ff && state_ff != ST_OFF && (ED_AUTO_START_I || ED_MANUAL_START_I))
         begin
            ed_cnt_ff <= 14'(ed_syms * dec_ff.sym_cyc) - 14'h0001;
            ed_run_ff <= 1'b1;
            ed_peak_ff <= RSSI_I;
         end
         else if (ed_run_ff)
         begin
            if (RSSI_I > ed_peak_ff)
            begin
               ed_peak_ff <= RSSI_I;
            end
            if (ed_cnt_ff == '0)
            begin
               ed_run_ff <= 1'b0;
               ed_done_ff <= 1'b1;
               energy_level_ff <= {3'h0, (RSSI_I > ed_peak_ff) ? RSSI_I : ed_peak_ff};
            end
            else
            begin
               ed_cnt_ff <= ed_cnt_ff - 14'h0001;
            end
         end
      end
   end

   // carrier sense not offered in high rate modes
   assign CCA_MODE_O = dec_ff.high_rate ? CCA_ENERGY : CCA_MODE_I;

   // status outputs
   assign SYMBOL_TICK_O = sym_tick_ff;
   assign SYMBOL_PERIOD_US_O = dec_ff.sym_us;
   assign SPREAD_FACTOR_O = dec_ff.spread;
   assign HIGH_RATE_MODE_O = dec_ff.high_rate;
   assign HIGH_RATE_ACTIVE_O = dec_ff.high_rate && psdu_ff;
   assign DATA_RATE_KBPS_O = rate_ff;
   assign SCRAMBLE_EN_O = dec_ff.scramble;
   assign LQI_USEFUL_O = !dec_ff.high_rate;
   assign MODE_O = mode_ff;
   assign ACK_DUE_O = ack_due_ff;
   assign ACK_SYMBOLS_O = ack_syms;
   assign ED_BUSY_O = ed_run_ff;
   assign ED_DONE_O = ed_done_ff;
   assign ENERGY_LEVEL_O = energy_level_ff;
   assign FCS_VALID_O = fcs_valid_ff;

   // transceiver state field; appending still counts as busy
   always_comb
   begin
      unique case (state_ff)
         ST_OFF: STATE_O = STAT_OFF;
         ST_LISTEN: STATE_O = STAT_RX_ON;
         ST_BUSY, ST_APPEND: STATE_O = STAT_BUSY_RX;
      endcase
   end
endmodule : spm_phy_ctrl

// ===== pkg/spm_pkg.sv
package spm_pkg;
   // clock rate in MHz; cycle counts below derive from it
   localparam int CLK_MHZ = 20;
   // symbol periods in microseconds
   localparam int SYM_US_BPSK20 = 50;
   localparam int SYM_US_BPSK40 = 25;
   localparam int SYM_US_OQPSK400K = 40;
   localparam int SYM_US_OQPSK1000K = 16;
   // symbol periods in clock cycles
   localparam logic [9:0] SYM_CYC_BPSK20 = 10'(SYM_US_BPSK20 * CLK_MHZ);
   localparam logic [9:0] SYM_CYC_BPSK40 = 10'(SYM_US_BPSK40 * CLK_MHZ);
   localparam logic [9:0] SYM_CYC_OQPSK400K = 10'(SYM_US_OQPSK400K * CLK_MHZ);
   localparam logic [9:0] SYM_CYC_OQPSK1000K = 10'(SYM_US_OQPSK1000K * CLK_MHZ);
   // field positions inside the phy mode control word
   localparam int HRS_LSB = 0;
   localparam int RATE_BIT = 2;
   localparam int MOD_BIT = 3;
   localparam int ALT_BIT = 4;
   localparam int SCR_BIT = 5;
   // reset value: bpsk-20, scrambler enable set
   localparam logic [5:0] MODE_RESET = 6'h20;
   // high rate select codes
   localparam logic [1:0] HRS_BASE = 2'h0;
   localparam logic [1:0] HRS_X2 = 2'h1;
   localparam logic [1:0] HRS_X4 = 2'h2;
   localparam logic [1:0] HRS_X2_ALT = 2'h3;
   // acknowledgment and energy detection lengths in symbols
   localparam logic [3:0] ACK_SYM_STD = 4'hc;
   localparam logic [3:0] ACK_SYM_HR400K = 4'h2;
   localparam logic [3:0] ACK_SYM_HR1000K = 4'h3;
   localparam logic [3:0] ED_SYM_STD = 4'h8;
   localparam logic [3:0] ED_SYM_HR = 4'h2;
   // data rates in kb/s
   localparam logic [10:0] KBPS_20 = 11'h014;
   localparam logic [10:0] KBPS_40 = 11'h028;
   localparam logic [10:0] KBPS_100 = 11'h064;
   localparam logic [10:0] KBPS_250 = 11'h0fa;
   // clear channel assessment method codes
   localparam logic [1:0] CCA_ENERGY = 2'h1;
   // transceiver state field codes
   localparam logic [4:0] STAT_OFF = 5'h00;
   localparam logic [4:0] STAT_RX_ON = 5'h01;
   localparam logic [4:0] STAT_BUSY_RX = 5'h02;
   // rx status byte: fcs valid position
   localparam int RXS_FCS_BIT = 7;
   // index of the last of the bytes appended after frame data
   localparam logic [1:0] APPEND_LAST = 2'h2;

   // receive flow states
   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_LISTEN = 2'b01,
      ST_BUSY = 2'b10,
      ST_APPEND = 2'b11
   } spm_state_e;

   // decoded phy mode
   typedef struct packed {
      logic oqpsk;
      logic chip1000;
      logic high_rate;
      logic [2:0] spread;
      logic scramble;
      logic [9:0] sym_cyc;
      logic [5:0] sym_us;
      logic [10:0] base_kbps;
      logic [10:0] psdu_kbps;
   } spm_mode_s;

   // per-frame status appended to the buffer
   typedef struct packed {
      logic [7:0] lqi;
      logic [7:0] ed;
      logic [7:0] rx_status;
   } spm_frame_stat_s;
endpackage : spm_pkg

// ===== hw/spm_fifo.sv
`timescale 1ns/1ps
module spm_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_ff [DEPTH]; // storage
   logic [AW-1:0] wr_ptr_ff; // write index
   logic [AW-1:0] rd_ptr_ff; // read index
   logic [AW:0] count_ff; // fill level
   logic push; // accepted write
   logic pop; // accepted read

   assign in_ready_o = (count_ff != (AW+1)'(DEPTH));
   assign out_valid_o = (count_ff != '0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_ff[rd_ptr_ff];

   // storage write
   always_ff @(posedge clk_i)
   begin
      if (clk_en_i && push)
      begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end
      else if (clk_en_i)
      begin
         if (push)
         begin
            wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
         end
         if (pop)
         begin
            rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
         end
         if (push && !pop)
         begin
            count_ff <= count_ff + 1'b1;
         end
         else if (pop && !push)
         begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule : spm_fifo

// ===== tb/spm_phy_ctrl_checker.sv
`timescale 1ns/1ps
module spm_phy_ctrl_checker import spm_pkg::*; (
   input wire logic CLK_I,
   input wire logic RESET_N_I,
   input wire logic MODE_WR_I,
   input wire logic [5:0] MODE_DATA_I,
   input wire logic REDUCED_ACK_TIME_I,
   input wire logic [3:0] DETECTOR_LEVEL_I,
   input wire logic [4:0] RSSI_I,
   input wire logic SFD_FOUND_I,
   input wire logic FRAME_DONE_I,
   input wire logic [3:0] ACK_SYMBOLS_O,
   input wire logic [1:0] CCA_MODE_O,
   input wire logic SYMBOL_TICK_O,
   input wire logic [5:0] SYMBOL_PERIOD_US_O,
   input wire logic HIGH_RATE_MODE_O,
   input wire logic HIGH_RATE_ACTIVE_O,
   input wire logic [5:0] MODE_O,
   input wire logic [4:0] STATE_O
);
   // cycles since the last symbol tick
   logic [10:0] gap_ff;
   // a tick was seen since leaving off
   logic seen_ff;
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RESET_N_I);
   // tick spacing, cleared while off
   always_ff @(posedge CLK_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         gap_ff <= 11'h000;
         seen_ff <= 1'b0;
      end
      else if (STATE_O == STAT_OFF)
      begin
         gap_ff <= 11'h000;
         seen_ff <= 1'b0;
      end
      else
      begin
         gap_ff <= SYMBOL_TICK_O ? 11'h001 : gap_ff + 11'h001;
         seen_ff <= seen_ff | SYMBOL_TICK_O;
      end
   end
   // busy frame end, trailer, listen
   sequence s_frame_end;
      STATE_O == STAT_BUSY_RX && FRAME_DONE_I;
   endsequence
   sequence s_back_listen;
      (STATE_O == STAT_BUSY_RX) [*3] ##[1:60] (STATE_O == STAT_RX_ON);
   endsequence
   a_mode_hold_busy: assert property (MODE_WR_I && STATE_O != STAT_OFF |=> $stable(MODE_O))
      else $error("mode changed outside off");
   a_mode_take_off: assert property (MODE_WR_I && STATE_O == STAT_OFF |=> MODE_O == $past(MODE_DATA_I))
      else $error("mode word not taken");
   a_ack_symbol_count: assert property (ACK_SYMBOLS_O == ((REDUCED_ACK_TIME_I && HIGH_RATE_MODE_O)
      ? ((SYMBOL_PERIOD_US_O == 6'h10) ? 4'h3 : 4'h2) : ACK_SYM_STD))
      else $error("ack symbol count wrong");
   a_cca_energy_only: assert property (HIGH_RATE_MODE_O |-> CCA_MODE_O == CCA_ENERGY)
      else $error("carrier sense in high rate");
   a_tick_period_exact: assert property (SYMBOL_TICK_O && seen_ff |->
      gap_ff == 11'(SYMBOL_PERIOD_US_O) * 11'(CLK_MHZ))
      else $error("tick spacing wrong");
   a_rssi_gate_low: assert property (STATE_O == STAT_RX_ON && SFD_FOUND_I &&
      RSSI_I < {1'b0, DETECTOR_LEVEL_I} |=> STATE_O != STAT_BUSY_RX)
      else $error("weak frame accepted");
   a_frame_back_listen: assert property (s_frame_end |=> s_back_listen)
      else $error("no return to listen");
   a_psdu_rate_phase: assert property (HIGH_RATE_ACTIVE_O |-> HIGH_RATE_MODE_O && STATE_O == STAT_BUSY_RX)
      else $error("high rate outside payload");
endmodule : spm_phy_ctrl_checker

bind spm_phy_ctrl spm_phy_ctrl_checker u_spm_phy_ctrl_checker (.*);

// ===== tb/spm_host_model.sv
`timescale 1ns/1ps
module spm_host_model (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic stall_i,
   input wire logic buf_valid_i,
   output logic buf_ready_o,
   output logic pop_o
);
   // stall phase
   logic [2:0] phase_ff;
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         phase_ff <= 3'h0;
      else
         phase_ff <= phase_ff + 3'h1;
   end
   // ready six cycles in eight unless held off
   always_ff @(posedge clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         buf_ready_o <= 1'b0;
      else
         buf_ready_o <= !stall_i && (phase_ff[2:1] != 2'h3);
   end
   // byte taken on valid and ready
   assign pop_o = buf_valid_i && buf_ready_o;
endmodule : spm_host_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import spm_pkg::*;;
   logic clk = 1'b0, rst_n = 1'b0, red = 1'b0, fcs = 1'b0, rxv = 1'b0, stall = 1'b1;
   logic [9:0] pls = 10'h000; // command pulses
   logic [5:0] md = 6'h00, m;
   logic [3:0] det = 4'h0, acks;
   logic [4:0] rssi = 5'h11, st;
   logic [7:0] lqi = 8'h00, rxd = 8'h00, en, bd, b;
   logic [1:0] cca = 2'h2, ccao;
   logic rdy, edd, ackd, hr, scr, lqu, hra, fv, bv, br, pop;
   logic [2:0] sp;
   logic [10:0] rt;
   logic [5:0] per, mo;
   logic [7:0] exp_q[$]; // bytes owed to host
   logic [5:0] fix [3] = '{6'h0a, 6'h29, 6'h2e};
   int seed = 32'h328f, err_total = 0, samples_checked = 0, n, i;
   spm_phy_ctrl u_spm_phy_ctrl (.CLK_I(clk), .RESET_N_I(rst_n), .CLK_EN_I(1'b1), .MODE_WR_I(pls[0]),
      .MODE_DATA_I(md), .REDUCED_ACK_TIME_I(red), .DETECTOR_LEVEL_I(det), .RX_ON_CMD_I(pls[1]),
      .OFF_CMD_I(pls[2]), .RSSI_I(rssi), .SYNC_FOUND_I(pls[3]), .SFD_FOUND_I(pls[4]), .PSDU_START_I(pls[5]),
      .FRAME_DONE_I(pls[6]), .FCS_OK_I(fcs), .LQI_I(lqi), .RX_DATA_VALID_I(rxv), .RX_DATA_I(rxd),
      .RX_DATA_READY_O(rdy), .ED_AUTO_START_I(pls[7]), .ED_MANUAL_START_I(pls[8]), .ED_BUSY_O(),
      .ED_DONE_O(edd), .ENERGY_LEVEL_O(en), .ACK_START_I(pls[9]), .ACK_DUE_O(ackd), .ACK_SYMBOLS_O(acks),
      .CCA_MODE_I(cca), .CCA_MODE_O(ccao), .SYMBOL_TICK_O(), .SYMBOL_PERIOD_US_O(per), .SPREAD_FACTOR_O(sp),
      .HIGH_RATE_MODE_O(hr), .HIGH_RATE_ACTIVE_O(hra), .DATA_RATE_KBPS_O(rt), .SCRAMBLE_EN_O(scr),
      .LQI_USEFUL_O(lqu), .MODE_O(mo), .STATE_O(st), .FCS_VALID_O(fv), .BUF_VALID_O(bv), .BUF_DATA_O(bd),
      .BUF_READY_I(br));
   spm_host_model u_spm_host_model (.clk_i(clk), .reset_n_i(rst_n), .stall_i(stall), .buf_valid_i(bv),
      .buf_ready_o(br), .pop_o(pop));
   // expected hr, scr, spread, period
   function automatic logic [10:0] dec(input logic [5:0] w);
      logic h;
      h = w[MOD_BIT] && (w[1:0] != HRS_BASE);
      return {h, h && w[1:0] == HRS_X4 && w[SCR_BIT], !h ? 3'h1 : (w[1:0] == HRS_X4 ? 3'h4 : 3'h2),
         w[MOD_BIT] ? (w[RATE_BIT] ? 6'h10 : 6'h28) : (w[RATE_BIT] ? 6'h19 : 6'h32)};
   endfunction : dec
   task automatic cmp_val(input logic [11:0] got, input logic [11:0] want);
      samples_checked++;
      if (got !== want)
      begin
         err_total++;
         $display("[ERR] %0t value %h expected %h", $time, got, want);
      end
   endtask : cmp_val
   task automatic cmp_byte(input logic [7:0] got, input logic [7:0] want);
      cmp_val({4'h0, got}, {4'h0, want});
   endtask : cmp_byte
   task automatic wrap_up;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up
   task automatic pulse(input int k);
      @(posedge clk);
      pls[k] <= 1'b1;
      @(posedge clk);
      pls[k] <= 1'b0;
   endtask : pulse
   task automatic wr_mode(input logic [5:0] w);
      md <= w;
      pulse(0);
      @(posedge clk);
      @(negedge clk);
   endtask : wr_mode
   // start to done cycles
   task automatic timing(input int k, input int want);
      int c;
      pulse(k);
      for (c = -1; c < 5000 && !(k == 9 ? ackd : edd); c++)
         @(negedge clk);
      cmp_val(12'(c), 12'(want));
   endtask : timing
   task automatic send(input logic [7:0] v);
      @(posedge clk);
      rxv <= 1'b1;
      rxd <= v;
      @(negedge clk);
      for (n = 0; n < 300 && !rdy; n++)
         @(negedge clk);
      if (n == 300) err_total++;
      @(posedge clk);
      rxv <= 1'b0;
      exp_q.push_back(v);
   endtask : send
   initial
      forever #25 clk = ~clk;
   // host reads, in order
   always @(posedge clk)
      if (pop)
         cmp_byte(bd, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx);
   initial
   begin
      repeat (100000) @(posedge clk);
      err_total++;
      wrap_up();
   end
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      cmp_val({6'h0, mo}, {6'h0, MODE_RESET});
      for (i = 0; i < 15; i++)
      begin
         m = (i < 3) ? fix[i] : 6'($random(seed));
         if (!m[MOD_BIT])
            m[1:0] = HRS_BASE;
         wr_mode(m);
         cmp_val({1'b0, hr, scr, sp, per}, {1'b0, dec(m)});
      end
      wr_mode(6'h2e);
      pulse(1);
      wr_mode(6'h00);
      cmp_val({6'h0, mo}, 12'h02e);
      red <= 1'b1;
      @(negedge clk);
      cmp_val({lqu, ccao, acks}, {1'b0, CCA_ENERGY, 4'h3});
      timing(9, 960);
      red <= 1'b0;
      timing(9, 3840);
      timing(7, 640);
      timing(8, 2560);
      cmp_byte(en, 8'h11);
      det <= 4'h8;
      rssi <= 5'h03;
      pulse(3);
      pulse(4);
      @(negedge clk);
      cmp_val({7'h0, st}, {7'h0, STAT_RX_ON});
      rssi <= 5'h11;
      pulse(3);
      pulse(4);
      @(negedge clk);
      cmp_val({6'h0, hra, st}, {7'h0, STAT_BUSY_RX});
      cmp_val({1'b0, rt}, 12'h0fa);
      pulse(5);
      @(negedge clk);
      cmp_val({11'h0, hra}, 12'h001);
      for (i = 0; i < 12; i++)
      begin
         if (i == 8)
         begin
            @(negedge clk);
            cmp_val({11'h0, rdy}, 12'h000);
            stall <= 1'b0;
         end
         b = 8'($random(seed));
         send(b);
      end
      cmp_val({1'b0, rt}, 12'h3e8);
      lqi <= 8'h5a;
      fcs <= 1'b1;
      pulse(6);
      exp_q.push_back(8'h5a);
      exp_q.push_back(8'h11);
      exp_q.push_back(8'h80);
      for (n = 0; n < 200 && st !== STAT_RX_ON; n++)
         @(negedge clk);
      cmp_val({6'h0, fv, st}, {6'h1, STAT_RX_ON});
      for (n = 0; n < 200 && exp_q.size() > 0; n++)
         @(negedge clk);
      cmp_val(12'(exp_q.size()), 12'h000);
      pulse(2);
      @(negedge clk);
      cmp_val({7'h0, st}, {7'h0, STAT_OFF});
      wrap_up();
   end
endmodule : tb_top
